// ---- hdl/rfb_frame_buffer.v ----
// Radio frame buffer: 128-byte dual-port store with host and baseband ports,
// underrun detection and the transmit power / auto checksum control register.
// Assumes host strobes come from logic on i_sys_clk; the sleep, power-on and
// transmit trigger pins are asynchronous and are synchronised here.
`timescale 1ns/10ps
`include "rfb_regs.vh"
module rfb_frame_buffer (
    input  wire                  i_sys_clk,
    input  wire                  i_reset,
    input  wire                  i_clk_en,
    input  wire                  i_sleep_state,
    input  wire                  i_power_on_state,
    input  wire                  i_sleep_tx_trigger_pin,
    input  wire                  i_reg_wr,
    input  wire                  i_reg_rd,
    input  wire [5:0]            i_reg_addr,
    input  wire [7:0]            i_reg_wdata,
    output reg  [7:0]            o_reg_rdata,
    input  wire                  i_host_frame_mode,
    input  wire                  i_host_start,
    input  wire                  i_host_rd,
    input  wire                  i_host_wr,
    input  wire [6:0]            i_host_addr,
    input  wire [7:0]            i_host_wdata,
    output reg  [7:0]            o_host_rdata,
    output reg                   o_host_rvalid,
    input  wire                  i_underrun_ack,
    output reg                   o_buffer_underrun_event,
    input  wire                  i_rx_state,
    input  wire                  i_auto_retry_tx_state,
    input  wire                  i_rx_start,
    input  wire                  i_rx_byte_valid,
    input  wire [7:0]            i_rx_byte,
    input  wire                  i_rx_done,
    input  wire [7:0]            i_link_quality_value,
    output reg  [7:0]            o_rx_length,
    input  wire                  i_tx_start,
    input  wire                  i_tx_byte_req,
    output reg  [7:0]            o_tx_byte,
    output reg                   o_tx_byte_valid,
    output reg                   o_tx_trigger_edge,
    output wire [3:0]            o_pa_power_level,
    output wire                  o_auto_fcs_en,
    output wire                  o_buffer_powered
);
    localparam BB_IDLE = 3'b001;
    localparam BB_RX   = 3'b010;
    localparam BB_TX   = 3'b100;

    reg  [7:0]  mem [0:`RFB_DEPTH-1];
    reg  [7:0]  tx_power_fcs_ctrl;
    reg  [2:0]  bb_state;
    reg  [6:0]  host_ptr;
    reg  [6:0]  bb_ptr;
    reg  [7:0]  tx_len;
    reg  [10:0] rx_timer;
    reg         rx_armed;
    reg         rx_storing;
    reg         host_reading;
    reg         host_writing;
    reg         host_len_pending;
    reg         trig_q;
    reg  [15:0] fcs;
    reg  [15:0] next_fcs;
    reg  [1:0]  fcs_idx;
    integer     k;

    wire sleep_s;
    wire pon_s;
    wire trig_s;
    wire powered;
    wire rx_store_ok;
    wire host_rd_ok;
    wire host_wr_ok;
    wire read_violation;
    wire write_violation;
    wire ur_window_ok;
    wire tx_in_fcs;
    wire [7:0] tx_data_count;

    rfb_sync2 u_sync_sleep (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .i_clk_en  (i_clk_en),
        .i_async   (i_sleep_state),
        .o_sync    (sleep_s)
    );
    rfb_sync2 u_sync_pon (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .i_clk_en  (i_clk_en),
        .i_async   (i_power_on_state),
        .o_sync    (pon_s)
    );
    rfb_sync2 u_sync_trig (
        .i_sys_clk (i_sys_clk),
        .i_reset   (i_reset),
        .i_clk_en  (i_clk_en),
        .i_async   (i_sleep_tx_trigger_pin),
        .o_sync    (trig_s)
    );

    assign powered          = ~sleep_s & ~pon_s;
    assign o_buffer_powered = powered;
    assign o_pa_power_level = tx_power_fcs_ctrl[`RFB_PA_POWER_MSB:`RFB_PA_POWER_LSB];
    assign o_auto_fcs_en    = tx_power_fcs_ctrl[`RFB_AUTO_FCS_BIT];

    assign rx_store_ok = rx_storing & i_rx_byte_valid & powered;
    assign host_rd_ok  = i_host_rd & powered;
    assign host_wr_ok  = i_host_wr & powered;

    assign read_violation  = host_rd_ok & host_reading & ~host_len_pending
                             & (bb_state == BB_RX) & (host_ptr >= bb_ptr);
    assign write_violation = host_wr_ok & host_writing & (bb_state == BB_TX)
                             & (host_ptr <= bb_ptr);
    assign ur_window_ok = ~rx_armed | (rx_timer >= `RFB_UR_VALID_CYC);

    assign tx_data_count = (tx_len > 8'h00) ? tx_len : 8'h01;
    assign tx_in_fcs     = o_auto_fcs_en &&
                           ({1'b0, bb_ptr} + `RFB_FCS_BYTES >= {1'b0, tx_data_count});

    always @* begin
        next_fcs = fcs;
        for (k = 0; k < 8; k = k + 1) begin
            if (next_fcs[0] ^ o_tx_byte[k]) begin
                next_fcs = (next_fcs >> 1) ^ `RFB_FCS_POLY_REV;
            end else begin
                next_fcs = next_fcs >> 1;
            end
        end
    end

    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            tx_power_fcs_ctrl <= `RFB_TX_POWER_FCS_CTRL_RESET;
            o_reg_rdata       <= `RFB_BYTE_ZERO;
        end else if (i_clk_en) begin
            if (i_reg_wr && i_reg_addr == `RFB_ADDR_TX_POWER_FCS_CTRL) begin
                tx_power_fcs_ctrl <= i_reg_wdata & `RFB_CTRL_WRITE_MASK;
            end
            if (i_reg_rd && i_reg_addr == `RFB_ADDR_TX_POWER_FCS_CTRL) begin
                o_reg_rdata <= tx_power_fcs_ctrl;
            end else if (i_reg_rd) begin
                o_reg_rdata <= `RFB_BYTE_ZERO;
            end
        end
    end

    always @(posedge i_sys_clk) begin
        if (i_clk_en) begin
            if (host_wr_ok && !(i_host_frame_mode && host_len_pending)) begin
                mem[i_host_frame_mode ? host_ptr : i_host_addr] <= i_host_wdata;
            end
            if (rx_store_ok) begin
                mem[bb_ptr] <= i_rx_byte;
            end else if (rx_storing && i_rx_done && powered) begin
                mem[bb_ptr] <= i_link_quality_value;
            end
        end
    end

    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            bb_state          <= BB_IDLE;
            host_ptr          <= `RFB_PTR_ZERO;
            bb_ptr            <= `RFB_PTR_ZERO;
            tx_len            <= `RFB_BYTE_ZERO;
            o_rx_length       <= `RFB_BYTE_ZERO;
            rx_timer          <= `RFB_TMR_ZERO;
            rx_armed          <= 1'b0;
            rx_storing        <= 1'b0;
            host_reading      <= 1'b0;
            host_writing      <= 1'b0;
            host_len_pending  <= 1'b0;
            trig_q            <= 1'b0;
            fcs               <= `RFB_FCS_INIT;
            fcs_idx           <= 2'b00;
            o_host_rdata      <= `RFB_BYTE_ZERO;
            o_host_rvalid     <= 1'b0;
            o_tx_byte         <= `RFB_BYTE_ZERO;
            o_tx_byte_valid   <= 1'b0;
            o_tx_trigger_edge <= 1'b0;
            o_buffer_underrun_event <= 1'b0;
        end else if (i_clk_en) begin
            trig_q            <= trig_s;
            o_tx_trigger_edge <= trig_s & ~trig_q;
            o_host_rvalid     <= 1'b0;
            o_tx_byte_valid   <= 1'b0;
            if (i_host_start) begin
                host_ptr         <= `RFB_PTR_ZERO;
                host_reading     <= 1'b0;
                host_writing     <= 1'b0;
                host_len_pending <= i_host_frame_mode;
            end
            if (host_rd_ok) begin
                o_host_rvalid <= 1'b1;
                if (!i_host_frame_mode) begin
                    o_host_rdata <= mem[i_host_addr];
                end else if (host_len_pending) begin
                    o_host_rdata     <= o_rx_length;
                    host_len_pending <= 1'b0;
                    host_reading     <= 1'b1;
                end else begin
                    o_host_rdata <= mem[host_ptr];
                    host_ptr     <= host_ptr + `RFB_PTR_ONE;
                    host_reading <= 1'b1;
                end
            end
            if (host_wr_ok && i_host_frame_mode) begin
                host_writing <= 1'b1;
                if (host_len_pending) begin
                    tx_len           <= i_host_wdata;
                    host_len_pending <= 1'b0;
                end else begin
                    host_ptr <= host_ptr + `RFB_PTR_ONE;
                end
            end
            if ((read_violation && ur_window_ok) || write_violation) begin
                o_buffer_underrun_event <= 1'b1;
            end else if (i_underrun_ack) begin
                o_buffer_underrun_event <= 1'b0;
            end
            if (rx_armed && rx_timer != `RFB_TMR_W'h7FF) begin
                rx_timer <= rx_timer + `RFB_TMR_ONE;
            end
            case (bb_state)
                BB_IDLE: begin
                    if (i_tx_start && powered) begin
                        bb_state <= BB_TX;
                        bb_ptr   <= `RFB_PTR_ZERO;
                        fcs      <= `RFB_FCS_INIT;
                        fcs_idx  <= 2'b00;
                    end
                end
                BB_RX: begin
                    if (!rx_storing && rx_timer >= `RFB_RX_WRITE_DELAY_CYC - 1) begin
                        rx_storing <= 1'b1;
                        bb_ptr     <= `RFB_PTR_ZERO;
                    end
                    if (rx_store_ok && bb_ptr != `RFB_PTR_LAST) begin
                        bb_ptr <= bb_ptr + `RFB_PTR_ONE;
                    end
                    if (i_rx_done) begin
                        bb_state   <= BB_IDLE;
                        rx_storing <= 1'b0;
                        rx_armed   <= 1'b0;
                    end
                end
                BB_TX: begin
                    if (i_tx_byte_req) begin
                        o_tx_byte_valid <= 1'b1;
                        if (tx_in_fcs) begin
                            o_tx_byte <= (fcs_idx == 2'b00) ? fcs[7:0] : fcs[15:8];
                            fcs_idx   <= fcs_idx + 2'b01;
                        end else begin
                            o_tx_byte <= mem[bb_ptr];
                        end
                        if ({1'b0, bb_ptr} + 8'h01 >= tx_data_count) begin
                            bb_state <= BB_IDLE;
                        end else begin
                            bb_ptr <= bb_ptr + `RFB_PTR_ONE;
                        end
                    end
                    if (o_tx_byte_valid && fcs_idx == 2'b00) begin
                        fcs <= next_fcs;
                    end
                end
                default: begin
                    bb_state <= BB_IDLE;
                end
            endcase
            if (i_rx_start && i_rx_state && !i_auto_retry_tx_state && powered) begin
                bb_state   <= BB_RX;
                rx_armed   <= 1'b1;
                rx_storing <= 1'b0;
                rx_timer   <= `RFB_TMR_ZERO;
                if (host_reading && i_host_frame_mode) begin
                    o_buffer_underrun_event <= 1'b1;
                end
            end
            if (i_rx_start && i_rx_state && !i_auto_retry_tx_state) begin
                o_rx_length <= `RFB_BYTE_ZERO;
            end
            if (rx_store_ok) begin
                o_rx_length <= o_rx_length + 8'h01;
            end
            if (!powered) begin
                bb_state         <= BB_IDLE;
                rx_storing       <= 1'b0;
                rx_armed         <= 1'b0;
                tx_len           <= `RFB_BYTE_ZERO;
                o_rx_length      <= `RFB_BYTE_ZERO;
                host_reading     <= 1'b0;
                host_writing     <= 1'b0;
                host_len_pending <= 1'b0;
            end
        end
    end
endmodule

// ---- hdl/rfb_regs.vh ----
// Constants for the radio frame buffer: register map, fields, sizes and timing.
// Assumes a 25 MHz system clock; included by the frame buffer design files.
`ifndef RFB_REGS_VH
`define RFB_REGS_VH
`define RFB_ADDR_TX_POWER_FCS_CTRL  6'h05
`define RFB_TX_POWER_FCS_CTRL_RESET 8'h00
`define RFB_AUTO_FCS_BIT            7
`define RFB_PA_POWER_MSB            3
`define RFB_PA_POWER_LSB            0
`define RFB_CTRL_WRITE_MASK         8'h8F
`define RFB_DEPTH                   128
`define RFB_PTR_W                   7
`define RFB_PTR_ZERO                7'h00
`define RFB_PTR_ONE                 7'h01
`define RFB_PTR_LAST                7'h7F
`define RFB_CLK_MHZ                 25
`define RFB_RX_WRITE_DELAY_US       32
`define RFB_UR_VALID_US             64
`define RFB_RX_WRITE_DELAY_CYC      (`RFB_RX_WRITE_DELAY_US * `RFB_CLK_MHZ)
`define RFB_UR_VALID_CYC            (`RFB_UR_VALID_US * `RFB_CLK_MHZ)
`define RFB_TMR_W                   11
`define RFB_TMR_ZERO                11'h000
`define RFB_TMR_ONE                 11'h001
`define RFB_FCS_INIT                16'h0000
`define RFB_FCS_POLY_REV            16'h8408
`define RFB_FCS_BYTES               2
`define RFB_BYTE_ZERO               8'h00
`endif

// ---- hdl/rfb_sync2.v ----
// Two flip-flop synchroniser for one level from outside the clock domain.
// Assumes the input is asynchronous to i_sys_clk.
`timescale 1ns/10ps
module rfb_sync2 (
    input  wire i_sys_clk,
    input  wire i_reset,
    input  wire i_clk_en,
    input  wire i_async,
    output reg  o_sync
);
    reg stage1;

    always @(posedge i_sys_clk or posedge i_reset) begin
        if (i_reset) begin
            stage1 <= 1'b0;
            o_sync <= 1'b0;
        end else if (i_clk_en) begin
            stage1 <= i_async;
            o_sync <= stage1;
        end
    end
endmodule

// ---- testbench/rfb_frame_buffer_checker.sv ----
// Assertions on the ports of the radio frame buffer.
// Assumes it is bound to rfb_frame_buffer and sees only its ports.
`timescale 1ns/10ps
module rfb_frame_buffer_checker (
    input wire       i_sys_clk,
    input wire       i_reset,
    input wire       i_clk_en,
    input wire       i_sleep_state,
    input wire       i_reg_wr,
    input wire       i_reg_rd,
    input wire [5:0] i_reg_addr,
    input wire [7:0] i_reg_wdata,
    input wire [7:0] o_reg_rdata,
    input wire       i_host_frame_mode,
    input wire       i_host_rd,
    input wire       o_host_rvalid,
    input wire       i_underrun_ack,
    input wire       o_buffer_underrun_event,
    input wire       i_tx_byte_req,
    input wire       o_tx_byte_valid,
    input wire [3:0] o_pa_power_level,
    input wire       o_auto_fcs_en,
    input wire       o_buffer_powered
);
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_reset);
    sequence ctrl_rd_s;
        i_reg_rd && !i_reg_wr && i_clk_en && i_reg_addr == 6'h05;
    endsequence
    sequence asleep_s;
        (i_sleep_state && i_clk_en)[*3];
    endsequence
    power_write_a: assert property (
        i_reg_wr && i_clk_en && i_reg_addr == 6'h05 |=> o_pa_power_level ==
        $past(i_reg_wdata[3:0]) && o_auto_fcs_en == $past(i_reg_wdata[7]))
        else $error("power field not taken from write");
    ctrl_readback_a: assert property (
        ctrl_rd_s |=> o_reg_rdata == {$past(o_auto_fcs_en), 3'h0, $past(o_pa_power_level)})
        else $error("control register read wrong");
    unmapped_read_a: assert property (
        i_reg_rd && i_clk_en && i_reg_addr != 6'h05 |=> o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    host_answer_a: assert property (
        i_host_rd && i_clk_en && o_buffer_powered |=> o_host_rvalid)
        else $error("host read not answered");
    rvalid_cause_a: assert property (
        o_host_rvalid |-> $past(i_host_rd))
        else $error("read valid without read");
    underrun_hold_a: assert property (
        o_buffer_underrun_event && !i_underrun_ack |=> o_buffer_underrun_event)
        else $error("underrun dropped without ack");
    underrun_mode_a: assert property (
        $rose(o_buffer_underrun_event) |-> $past(i_host_frame_mode))
        else $error("underrun in random mode");
    sleep_off_a: assert property (
        asleep_s |-> !o_buffer_powered)
        else $error("buffer powered in sleep");
    tx_cause_a: assert property (
        o_tx_byte_valid |-> $past(i_tx_byte_req))
        else $error("transmit byte without request");
endmodule
bind rfb_frame_buffer rfb_frame_buffer_checker rfb_frame_buffer_checker_i (
    .i_sys_clk(i_sys_clk), .i_reset(i_reset), .i_clk_en(i_clk_en),
    .i_sleep_state(i_sleep_state), .i_reg_wr(i_reg_wr), .i_reg_rd(i_reg_rd),
    .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata), .o_reg_rdata(o_reg_rdata),
    .i_host_frame_mode(i_host_frame_mode), .i_host_rd(i_host_rd),
    .o_host_rvalid(o_host_rvalid), .i_underrun_ack(i_underrun_ack),
    .o_buffer_underrun_event(o_buffer_underrun_event), .i_tx_byte_req(i_tx_byte_req),
    .o_tx_byte_valid(o_tx_byte_valid), .o_pa_power_level(o_pa_power_level),
    .o_auto_fcs_en(o_auto_fcs_en), .o_buffer_powered(o_buffer_powered)
);

// ---- testbench/rfb_host_model.sv ----
// Host model: register and frame buffer accesses on the falling clock edge.
// Assumes the bench calls its tasks one at a time.
`timescale 1ns/10ps
module rfb_host_model (
    input  wire       i_sys_clk,
    input  wire [7:0] i_reg_rdata,
    input  wire [7:0] i_host_rdata,
    input  wire       i_host_rvalid,
    output reg        o_reg_wr,
    output reg        o_reg_rd,
    output reg  [5:0] o_reg_addr,
    output reg  [7:0] o_reg_wdata,
    output reg        o_host_frame_mode,
    output reg        o_host_start,
    output reg        o_host_rd,
    output reg        o_host_wr,
    output reg  [6:0] o_host_addr,
    output reg  [7:0] o_host_wdata,
    output reg        o_underrun_ack
);
    initial begin
        {o_reg_wr, o_reg_rd, o_host_frame_mode, o_host_start} = 4'h0;
        {o_host_rd, o_host_wr, o_underrun_ack} = 3'h0;
        o_reg_addr = 6'h00;
        o_reg_wdata = 8'h00;
        o_host_addr = 7'h00;
        o_host_wdata = 8'h00;
    end
    task reg_wr_t(input [5:0] a, input [7:0] dat);
        @(negedge i_sys_clk);
        o_reg_wr = 1'b1;
        o_reg_addr = a;
        o_reg_wdata = dat;
        @(negedge i_sys_clk);
        o_reg_wr = 1'b0;
        o_reg_wdata = ~dat;
    endtask
    task reg_rd_t(input [5:0] a, output [7:0] dat);
        @(negedge i_sys_clk);
        o_reg_rd = 1'b1;
        o_reg_addr = a;
        @(negedge i_sys_clk);
        o_reg_rd = 1'b0;
        dat = i_reg_rdata;
    endtask
    task host_wr_t(input [6:0] a, input [7:0] dat);
        @(negedge i_sys_clk);
        o_host_wr = 1'b1;
        o_host_addr = a;
        o_host_wdata = dat;
        @(negedge i_sys_clk);
        o_host_wr = 1'b0;
        o_host_wdata = ~dat;
    endtask
    task host_rd_t(input [6:0] a, output [7:0] dat, output vld);
        @(negedge i_sys_clk);
        o_host_rd = 1'b1;
        o_host_addr = a;
        @(negedge i_sys_clk);
        o_host_rd = 1'b0;
        dat = i_host_rdata;
        vld = i_host_rvalid;
    endtask
    task frame_t(input m, input ack);
        @(negedge i_sys_clk);
        o_host_frame_mode = m;
        o_host_start = m & ~ack;
        o_underrun_ack = ack;
        @(negedge i_sys_clk);
        o_host_start = 1'b0;
        o_underrun_ack = 1'b0;
    endtask
endmodule

// ---- testbench/rfb_frame_buffer_tb.sv ----
// Testbench: register, random access, receive, transmit underrun and sleep.
// Assumes the host model drives the host side; the bench drives the baseband side.
`timescale 1ns/10ps
`include "rfb_regs.vh"
module rfb_frame_buffer_tb;
    logic       clk, rst, sleep, rx_state, rx_start, rx_bv, rx_done, tx_start, tx_req, v, trig_pin;
    logic [7:0] rx_byte, link_quality_value, d;
    wire        reg_wr, reg_rd, fmode, hstart, hrd, hwr, ack, rvalid, ur, txv, pwr, afcs, trg;
    wire  [5:0] reg_addr;
    wire  [6:0] haddr;
    wire  [7:0] reg_wd, reg_rdat, hwd, hrdat, rxlen, txb;
    wire  [3:0] pa;
    integer     mismatches = 0;
    integer     samples_checked = 0;
    integer     i;
    rfb_host_model rfb_host_model_i (.i_sys_clk(clk), .i_reg_rdata(reg_rdat),
        .i_host_rdata(hrdat), .i_host_rvalid(rvalid), .o_reg_wr(reg_wr), .o_reg_rd(reg_rd),
        .o_reg_addr(reg_addr), .o_reg_wdata(reg_wd), .o_host_frame_mode(fmode),
        .o_host_start(hstart), .o_host_rd(hrd), .o_host_wr(hwr), .o_host_addr(haddr),
        .o_host_wdata(hwd), .o_underrun_ack(ack));
    rfb_frame_buffer rfb_frame_buffer_i (.i_sys_clk(clk), .i_reset(rst), .i_clk_en(1'b1),
        .i_sleep_state(sleep), .i_power_on_state(1'b0), .i_sleep_tx_trigger_pin(trig_pin),
        .i_reg_wr(reg_wr), .i_reg_rd(reg_rd), .i_reg_addr(reg_addr), .i_reg_wdata(reg_wd),
        .o_reg_rdata(reg_rdat), .i_host_frame_mode(fmode), .i_host_start(hstart),
        .i_host_rd(hrd), .i_host_wr(hwr), .i_host_addr(haddr), .i_host_wdata(hwd),
        .o_host_rdata(hrdat), .o_host_rvalid(rvalid), .i_underrun_ack(ack),
        .o_buffer_underrun_event(ur), .i_rx_state(rx_state), .i_auto_retry_tx_state(1'b0),
        .i_rx_start(rx_start), .i_rx_byte_valid(rx_bv), .i_rx_byte(rx_byte),
        .i_rx_done(rx_done), .i_link_quality_value(link_quality_value), .o_rx_length(rxlen),
        .i_tx_start(tx_start), .i_tx_byte_req(tx_req), .o_tx_byte(txb),
        .o_tx_byte_valid(txv), .o_tx_trigger_edge(trg), .o_pa_power_level(pa),
        .o_auto_fcs_en(afcs), .o_buffer_powered(pwr));
    task chk(input logic [7:0] got, input logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            mismatches++;
            $display("CHECK FAILED t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    task end_of_test;
        if (mismatches == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task rx_put(input logic [7:0] b);
        @(negedge clk);
        rx_bv = 1'b1;
        rx_byte = b;
        @(negedge clk);
        rx_bv = 1'b0;
        rx_byte = ~b;
    endtask
    task tx_get(input logic [7:0] exp);
        @(negedge clk);
        tx_req = 1'b1;
        @(negedge clk);
        tx_req = 1'b0;
        chk({7'h00, txv}, 8'h01);
        chk(txb, exp);
    endtask
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        repeat (4000) @(posedge clk);
        mismatches++;
        end_of_test;
    end
    initial begin
        {rst, sleep, rx_state, rx_start, rx_bv, rx_done, tx_start, tx_req} = 8'h80;
        rx_byte = 8'h00;
        trig_pin = 1'b0;
        link_quality_value = 8'h7C;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        rfb_host_model_i.reg_rd_t(6'h05, d);
        chk(d, `RFB_TX_POWER_FCS_CTRL_RESET);
        rfb_host_model_i.reg_wr_t(6'h05, 8'hFF);
        rfb_host_model_i.reg_rd_t(6'h05, d);
        chk(d, 8'h8F);
        chk({3'h0, afcs, pa}, 8'h1F);
        rfb_host_model_i.reg_rd_t(6'h06, d);
        chk(d, 8'h00);
        trig_pin = 1'b1;
        repeat (3) @(negedge clk);
        chk({7'h00, trg}, 8'h01);
        @(negedge clk);
        chk({7'h00, trg}, 8'h00);
        rfb_host_model_i.reg_wr_t(6'h05, 8'h00);
        for (i = 0; i < 4; i++) rfb_host_model_i.host_wr_t(7'h10 + i, 8'hA0 + i);
        for (i = 0; i < 4; i++) begin
            rfb_host_model_i.host_rd_t(7'h10 + i, d, v);
            chk(d, 8'hA0 + i);
        end
        chk({7'h00, ur}, 8'h00);
        rx_state = 1'b1;
        @(negedge clk) rx_start = 1'b1;
        @(negedge clk) rx_start = 1'b0;
        repeat (10) @(negedge clk);
        rx_put(8'h55);
        repeat (800) @(negedge clk);
        rx_put(8'h11);
        rx_put(8'h22);
        rx_put(8'h33);
        @(negedge clk) rx_done = 1'b1;
        @(negedge clk) rx_done = 1'b0;
        rx_state = 1'b0;
        chk(rxlen, 8'h03);
        rfb_host_model_i.frame_t(1'b1, 1'b0);
        rfb_host_model_i.host_rd_t(7'h00, d, v);
        chk(d, 8'h03);
        rfb_host_model_i.host_rd_t(7'h00, d, v);
        chk(d, 8'h11);
        rfb_host_model_i.host_rd_t(7'h00, d, v);
        rfb_host_model_i.host_rd_t(7'h00, d, v);
        rfb_host_model_i.host_rd_t(7'h00, d, v);
        chk(d, 8'h7C);
        rfb_host_model_i.frame_t(1'b1, 1'b1);
        rfb_host_model_i.frame_t(1'b1, 1'b0);
        rfb_host_model_i.host_wr_t(7'h00, 8'h05);
        rfb_host_model_i.host_wr_t(7'h00, 8'hAA);
        @(negedge clk) tx_start = 1'b1;
        @(negedge clk) tx_start = 1'b0;
        tx_get(8'hAA);
        tx_get(8'h22);
        rfb_host_model_i.host_wr_t(7'h00, 8'hBB);
        @(negedge clk);
        chk({7'h00, ur}, 8'h01);
        rfb_host_model_i.frame_t(1'b1, 1'b1);
        chk({7'h00, ur}, 8'h00);
        rx_state = 1'b1;
        @(negedge clk) rx_start = 1'b1;
        @(negedge clk) rx_start = 1'b0;
        repeat (1600) @(negedge clk);
        rx_put(8'h44);
        rfb_host_model_i.frame_t(1'b1, 1'b0);
        for (i = 0; i < 2; i++) rfb_host_model_i.host_rd_t(7'h00, d, v);
        chk(d, 8'h44);
        chk({7'h00, ur}, 8'h00);
        rfb_host_model_i.host_rd_t(7'h00, d, v);
        chk({7'h00, ur}, 8'h01);
        @(negedge clk) rx_done = 1'b1;
        @(negedge clk) rx_done = 1'b0;
        rx_state = 1'b0;
        rfb_host_model_i.frame_t(1'b1, 1'b1);
        rfb_host_model_i.reg_wr_t(6'h05, 8'h80);
        rfb_host_model_i.frame_t(1'b1, 1'b0);
        rfb_host_model_i.host_wr_t(7'h00, 8'h03);
        rfb_host_model_i.host_wr_t(7'h00, 8'h01);
        @(negedge clk) tx_start = 1'b1;
        @(negedge clk) tx_start = 1'b0;
        tx_get(8'h01);
        tx_get(8'h89);
        tx_get(8'h11);
        sleep = 1'b1;
        repeat (3) @(negedge clk);
        chk({7'h00, pwr}, 8'h00);
        rfb_host_model_i.host_rd_t(7'h00, d, v);
        chk({7'h00, v}, 8'h00);
        sleep = 1'b0;
        repeat (3) @(negedge clk);
        chk({7'h00, pwr}, 8'h01);
        chk(rxlen, 8'h00);
        end_of_test;
    end
endmodule
